// ### hdl/isa_master_cycle_sequencer.sv
`timescale 1ns/100ps
`include "isa_seq_defines.svh"
// Summary of operation
// - Upper address valid at least five T before address latch negates.
// - Upper address valid at least five T before memory command asserts.
// - System address and byte-high enable valid one T before latch negates.
// - System address valid at least two T before memory command asserts.
// - System address valid at least two T before I/O command asserts.
// - Address latch stays asserted at least one T.
// - Address latch asserts at least two T before memory command.
// - Address latch asserts at least two T before I/O command.
// - Address latch asserts at least eleven T before memory command negates.
// - Upper address held at least fourteen T after latch negates.
// - Memory command asserted at least thirteen T before upper address changes.
// - Memory command held asserted at least nine T in standard cycles.
// - I/O command held asserted at least nine T in standard cycles.
// - Memory command asserted at least ten T before system address changes.
// - Cycle lengths 2, 3, 4 BCLK for 16-bit, 2, 3, 7 BCLK for 8-bit.
// - Command strobes become valid within two T of the reference edge.

module isa_master_cycle_sequencer #(
  parameter logic [`ISA_CNT_W-1:0] T_ALE = `ISA_T_ALE,
  parameter logic [`ISA_CNT_W-1:0] T_HOLD = `ISA_T_HOLD
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Double-rate ISA clock, asynchronous to the core clock
  input wire logic ISA_DOUBLE_RATE_CLOCK,
  // Request side
  input wire logic REQ_VALID,
  input wire isa_seq_pkg::isa_req_t REQ,
  output logic REQ_READY,
  output logic REQ_ERROR,
  output logic DONE,
  // ISA bus side
  output logic [`ISA_LA_HI-`ISA_LA_LO:0] ISA_LA,
  output logic [`ISA_SA_HI:0] ISA_SA,
  output logic ISA_SBHE_N,
  output logic ISA_ALE_N,
  output isa_seq_pkg::isa_cmd_t ISA_CMD_N
);

  localparam isa_seq_pkg::isa_cmd_t CMD_IDLE = '{default: 1'b1};
  // A shortened phase would eat into the address margins, so the
  // parameters can only lengthen the latch and hold phases
  localparam logic [`ISA_CNT_W-1:0] ALE_LEN =
    (T_ALE < `ISA_T_ALE) ? `ISA_T_ALE : T_ALE;
  localparam logic [`ISA_CNT_W-1:0] HOLD_LEN =
    (T_HOLD < `ISA_T_HOLD) ? `ISA_T_HOLD : T_HOLD;

  // Edge detect on the double-rate clock
  logic clk_s1;
  logic clk_s2;
  logic clk_s3;

  // Sequencer state and the request held for the whole cycle
  isa_seq_pkg::seq_state_t state;
  isa_seq_pkg::seq_state_t next_state;
  isa_seq_pkg::isa_req_t req_r;

  // Phase timing
  logic [`ISA_CNT_W-1:0] cnt;
  logic [`ISA_CNT_W-1:0] cmd_ticks;
  logic [`ISA_CNT_W-1:0] limit;

  // Strobe select in the layout of the strobe word: strobe_on active high, cmd_sel its active-low copy
  wire isa_seq_pkg::isa_cmd_t strobe_on;
  wire isa_seq_pkg::isa_cmd_t cmd_sel;

  // Raw decode of the state and the counter
  wire tick;
  wire accept;
  wire bad_combo;
  wire phase_last;
  wire mem_low;
  wire start_addr;
  wire end_ale;
  wire end_cmd;
  wire end_hold;
  wire in_idle;
  wire in_sync;
  wire in_ale;
  wire in_cmd;
  wire in_hold;

  // Cycle events by name, so the flops below stay plain
  wire take;
  wire refuse;
  wire ready_next;
  wire load_addr;
  wire ale_on;
  wire ale_off;
  wire cmd_on;
  wire cmd_off;
  wire sel_io;
  wire sel_low;
  wire sel_high;

  // Only the second stage is read; the third is the edge reference
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
    end else begin
      clk_s1 <= ISA_DOUBLE_RATE_CLOCK;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end

  // One pulse per rising edge of the double-rate clock: the T unit
  assign tick = clk_s2 & ~clk_s3;

  // Named state decode
  assign in_idle = (state == isa_seq_pkg::ST_IDLE);
  assign in_sync = (state == isa_seq_pkg::ST_SYNC);
  assign in_ale = (state == isa_seq_pkg::ST_ALE);
  assign in_cmd = (state == isa_seq_pkg::ST_CMD);
  assign in_hold = (state == isa_seq_pkg::ST_HOLD);

  assign accept = REQ_VALID & in_idle;

  // 16-bit slaves have no 7 BCLK cycle, 8-bit slaves no 4 BCLK cycle
  assign bad_combo = REQ.wide ? (REQ.len == isa_seq_pkg::LEN_7BCLK) :
                                (REQ.len == isa_seq_pkg::LEN_4BCLK);

  assign take = accept & ~bad_combo;
  assign refuse = accept & bad_combo;
  assign ready_next = (next_state == isa_seq_pkg::ST_IDLE);
  assign load_addr = start_addr;
  assign ale_on = start_addr;
  assign ale_off = end_ale;
  assign cmd_on = end_ale;
  assign cmd_off = end_cmd;

  // Command width per cycle length, never under nine T; the short
  // cycles trade speed for the standard command width
  always_comb begin
    unique case (req_r.len)
      isa_seq_pkg::LEN_2BCLK: begin
        cmd_ticks = `ISA_T_CMD_2BCLK;
      end
      isa_seq_pkg::LEN_3BCLK: begin
        cmd_ticks = `ISA_T_CMD_3BCLK;
      end
      isa_seq_pkg::LEN_4BCLK: begin
        cmd_ticks = `ISA_T_CMD_4BCLK;
      end
      isa_seq_pkg::LEN_7BCLK: begin
        cmd_ticks = `ISA_T_CMD_7BCLK;
      end
    endcase
  end

  // Phase length for the current state; idle and sync phases
  // count one T; sync ends on the first tick, idle on a taken request
  always_comb begin
    unique case (state)
      isa_seq_pkg::ST_ALE: begin
        limit = ALE_LEN;
      end
      isa_seq_pkg::ST_CMD: begin
        limit = cmd_ticks;
      end
      isa_seq_pkg::ST_HOLD: begin
        limit = HOLD_LEN;
      end
      default: begin
        limit = `ISA_CNT_ONE;
      end
    endcase
  end

  assign phase_last = tick & (cnt == limit - `ISA_CNT_ONE);
  assign start_addr = tick & in_sync;
  assign end_ale = phase_last & in_ale;
  assign end_cmd = phase_last & in_cmd;
  assign end_hold = phase_last & in_hold;

  // Below 1 MB memory uses the system strobes, above it the full ones
  assign mem_low = (req_r.addr[`ISA_MB_HI:`ISA_MB_LO] == `ISA_MB_ZERO);

  // Space decode; below 1 MB the system strobes take the cycle
  assign sel_io = req_r.is_io;
  assign sel_low = ~req_r.is_io & mem_low;
  assign sel_high = ~req_r.is_io & ~mem_low;

  assign strobe_on.memr_n = sel_high & ~req_r.write;
  assign strobe_on.memw_n = sel_high & req_r.write;
  assign strobe_on.smemr_n = sel_low & ~req_r.write;
  assign strobe_on.smemw_n = sel_low & req_r.write;
  assign strobe_on.ior_n = sel_io & ~req_r.write;
  assign strobe_on.iow_n = sel_io & req_r.write;

  // Exactly one strobe low per cycle
  for (genvar i = 0; i < $bits(isa_seq_pkg::isa_cmd_t); i++) begin : g_sel
    assign cmd_sel[i] = ~strobe_on[i];
  end

  always_comb begin
    next_state = state;
    unique case (state)
      isa_seq_pkg::ST_IDLE:
        if (take) begin
          next_state = isa_seq_pkg::ST_SYNC;
        end
      isa_seq_pkg::ST_SYNC:
        if (start_addr) begin
          next_state = isa_seq_pkg::ST_ALE;
        end
      isa_seq_pkg::ST_ALE:
        if (end_ale) begin
          next_state = isa_seq_pkg::ST_CMD;
        end
      isa_seq_pkg::ST_CMD:
        if (end_cmd) begin
          next_state = isa_seq_pkg::ST_HOLD;
        end
      isa_seq_pkg::ST_HOLD:
        if (end_hold) begin
          next_state = isa_seq_pkg::ST_IDLE;
        end
      default: begin
        next_state = isa_seq_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= isa_seq_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counts whole T inside a phase; phases start on a tick
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt <= `ISA_CNT_RST;
    end else if (phase_last || start_addr) begin
      cnt <= `ISA_CNT_RST;
    end else if (tick) begin
      cnt <= cnt + `ISA_CNT_ONE;
    end
  end

  // A refused request must not disturb the request held last
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_r <= '0;
    end else if (take) begin
      req_r <= REQ;
    end
  end

  // Addresses change only at the start of a cycle, so they stay
  // valid past the hold phase until the next request
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ISA_LA <= '0;
    end else if (load_addr) begin
      ISA_LA <= req_r.addr[`ISA_LA_HI:`ISA_LA_LO];
    end
  end

  // System address loads with the upper address, one whole latch
  // phase before the latch negates
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ISA_SA <= '0;
    end else if (load_addr) begin
      ISA_SA <= req_r.addr[`ISA_SA_HI:0];
    end
  end

  // Byte-high enable travels with the system address
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ISA_SBHE_N <= 1'b1;
    end else if (load_addr) begin
      ISA_SBHE_N <= req_r.bhe_n;
    end
  end

  // Latch asserts with the address and negates after the latch
  // phase; it never overlaps the start of a command
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ISA_ALE_N <= 1'b1;
    end else if (ale_on) begin
      ISA_ALE_N <= 1'b0;
    end else if (ale_off) begin
      ISA_ALE_N <= 1'b1;
    end
  end

  // Command asserts as the latch negates: five T after address and
  // latch, then held; the hold phase covers address-change margins
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ISA_CMD_N <= CMD_IDLE;
    end else if (cmd_on) begin
      ISA_CMD_N <= cmd_sel;
    end else if (cmd_off) begin
      ISA_CMD_N <= CMD_IDLE;
    end
  end

  // Release only after the hold phase protects the addresses;
  // a single pulse, so no clear is needed
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DONE <= 1'b0;
    end else begin
      DONE <= end_hold;
    end
  end

  // A refused request leaves the bus untouched and the port ready;
  // the pulse names the refusal to the requester
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REQ_ERROR <= 1'b0;
    end else begin
      REQ_ERROR <= refuse;
    end
  end

  // Ready looks one edge ahead, so a request can follow in the
  // cycle that shows DONE
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REQ_READY <= 1'b0;
    end else begin
      REQ_READY <= ready_next;
    end
  end

endmodule // isa_master_cycle_sequencer

// ### include/isa_seq_defines.svh
`ifndef ISA_SEQ_DEFINES_SVH
`define ISA_SEQ_DEFINES_SVH

// Width of the phase counter, in double-rate clock periods (T)
`define ISA_CNT_W 5

// Phase lengths in T
`define ISA_T_ALE 5'h05
`define ISA_T_CMD_2BCLK 5'h09
`define ISA_T_CMD_3BCLK 5'h09
`define ISA_T_CMD_4BCLK 5'h0b
`define ISA_T_CMD_7BCLK 5'h11
`define ISA_T_HOLD 5'h05

// Address layout
`define ISA_ADDR_W 24
`define ISA_LA_HI 23
`define ISA_LA_LO 17
`define ISA_SA_HI 19
`define ISA_MB_HI 23
`define ISA_MB_LO 20
`define ISA_MB_ZERO 4'h0

// Reset values
`define ISA_ADDR_RST 24'h000000
`define ISA_CNT_RST 5'h00
`define ISA_CNT_ONE 5'h01

`endif

// ### include/isa_seq_pkg.sv
`include "isa_seq_defines.svh"

package isa_seq_pkg;

  typedef enum logic [1:0] {
    LEN_2BCLK,
    LEN_3BCLK,
    LEN_4BCLK,
    LEN_7BCLK
  } len_t;

  typedef struct packed {
    logic is_io;
    logic write;
    logic wide;
    len_t len;
    logic bhe_n;
    logic [`ISA_ADDR_W-1:0] addr;
  } isa_req_t;

  // Active-low command strobes
  typedef struct packed {
    logic memr_n;
    logic memw_n;
    logic smemr_n;
    logic smemw_n;
    logic ior_n;
    logic iow_n;
  } isa_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SYNC,
    ST_ALE,
    ST_CMD,
    ST_HOLD
  } seq_state_t;

endpackage

// ### dv/isa_seq_checker.sv
`timescale 1ns/100ps
module isa_seq_checker (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // Bus outputs
  input wire logic [6:0] ISA_LA,
  input wire logic [19:0] ISA_SA,
  input wire logic ISA_ALE_N,
  input wire isa_seq_pkg::isa_cmd_t ISA_CMD_N
);
  // One T is eight core cycles; counts saturate so a long idle never wraps
  wire logic cmd_on = ~&ISA_CMD_N;
  wire logic mem_on = ~&ISA_CMD_N[5:2];
  logic [7:0] ta;
  logic [7:0] tr;
  logic [7:0] tc;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ta <= 8'hff;
      tr <= 8'hff;
      tc <= 8'hff;
    end else begin
      ta <= $fell(ISA_ALE_N) ? 8'h01 : ta + 8'(~&ta);
      tr <= $rose(ISA_ALE_N) ? 8'h01 : tr + 8'(~&tr);
      tc <= $rose(cmd_on) ? 8'h01 : tc + 8'(~&tc);
    end
  end
  a_ale_width: assert property ($fell(ISA_ALE_N) |-> !ISA_ALE_N [*8])
    else $error("latch pulse too short");
  a_ale_cmd: assert property ($rose(cmd_on) |-> ta >= 8'h10)
    else $error("command too soon after latch");
  a_ale_cmd_end: assert property ($fell(cmd_on) |-> ta >= 8'h58)
    else $error("command ended too soon after latch");
  a_cmd_width: assert property ($fell(cmd_on) |-> tc >= 8'h48)
    else $error("command too short");
  a_sa_hold: assert property ($changed(ISA_SA) |-> tc >= 8'h50)
    else $error("low address changed too early");
  a_la_hold: assert property ($changed(ISA_LA) |->
    tr >= 8'h70 && tc >= 8'h68) else $error("upper address changed early");
  a_la_setup: assert property ($rose(ISA_ALE_N) |->
    ISA_LA == $past(ISA_LA, 40) && ISA_SA == $past(ISA_SA, 8))
    else $error("address not set up before latch end");
  a_cmd_setup: assert property ($rose(cmd_on) |->
    ISA_SA == $past(ISA_SA, 16) && (!mem_on || ISA_LA == $past(ISA_LA, 40)))
    else $error("address not set up before command");
  a_one_strobe: assert property ($onehot0(~ISA_CMD_N))
    else $error("more than one strobe active");
endmodule // isa_seq_checker

bind isa_master_cycle_sequencer isa_seq_checker u_chk(.CORE_CLK(CORE_CLK),
  .ARST_N(ARST_N), .ISA_LA(ISA_LA), .ISA_SA(ISA_SA),
  .ISA_ALE_N(ISA_ALE_N), .ISA_CMD_N(ISA_CMD_N));

// ### dv/isa_slave_model.sv
`timescale 1ns/100ps
module isa_slave_model (
  // Bus pins seen by the slave
  input wire logic ale_n,
  input wire logic [6:0] la,
  input wire logic [19:0] sa,
  input wire isa_seq_pkg::isa_cmd_t cmd_n,
  // What the slave decoded
  output logic [6:0] la_q,
  output logic [19:0] sa_q,
  output isa_seq_pkg::isa_cmd_t cmd_q
);
  wire logic idle = &cmd_n;
  // Upper address is only trusted at the trailing edge of the latch
  always @(posedge ale_n) la_q = la;
  always @(negedge idle) begin
    sa_q = sa;
    cmd_q = cmd_n;
  end
endmodule // isa_slave_model

// ### dv/isa_master_cycle_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "isa_seq_defines.svh"
module isa_master_cycle_sequencer_tb_top;
  logic clk = 0;
  logic rst_n = 0;
  logic isa_clk = 0;
  logic req_valid = 0;
  isa_seq_pkg::isa_req_t req = '0;
  wire logic ready, err, done, ale_n, sbhe_n;
  wire logic [6:0] la, la_q;
  wire logic [19:0] sa, sa_q;
  wire isa_seq_pkg::isa_cmd_t cmd_n, cmd_q;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  initial forever #20 clk = ~clk;
  initial begin
    #7;
    forever #160 isa_clk = ~isa_clk;
  end
  isa_master_cycle_sequencer u_dut(.CORE_CLK(clk), .ARST_N(rst_n),
    .ISA_DOUBLE_RATE_CLOCK(isa_clk), .REQ_VALID(req_valid), .REQ(req),
    .REQ_READY(ready), .REQ_ERROR(err), .DONE(done), .ISA_LA(la),
    .ISA_SA(sa), .ISA_SBHE_N(sbhe_n), .ISA_ALE_N(ale_n), .ISA_CMD_N(cmd_n));
  isa_slave_model u_slave(.ale_n(ale_n), .la(la), .sa(sa), .cmd_n(cmd_n),
    .la_q(la_q), .sa_q(sa_q), .cmd_q(cmd_q));
  task automatic conclude;
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  // One bus cycle; a zero width means the request must be refused
  task automatic run(input logic io, input logic wr, input logic wd,
    input logic [1:0] ln, input logic [23:0] ad, input logic [5:0] xc,
    input int xw);
    int w;
    int k;
    logic e;
    logic a;
    w = 0;
    a = 0;
    for (k = 0; k < 99 && ready !== 1'b1; k++) @(negedge clk);
    chk(ready, 1'b1);
    req = {io, wr, wd, ln, ad[0], ad};
    req_valid = 1;
    @(negedge clk);
    e = err;
    req_valid = 0;
    for (k = 0; k < 400 && done !== 1'b1; k++) begin
      @(negedge clk);
      e |= err;
      a |= !ale_n;
      w += int'(cmd_n !== 6'h3f);
    end
    chk(e, xw == 0);
    chk(a, xw != 0);
    chk(w, xw);
    chk(done, xw != 0);
    if (xw != 0) begin
      chk(cmd_q, xc);
      chk(la_q, ad[23:17]);
      chk(sa_q, ad[19:0]);
      chk(sbhe_n, ad[0]);
    end
  endtask
  task automatic t_memory;
    run(0, 0, 1, 2'h0, 24'hab_cde1, 6'h1f, 8 * `ISA_T_CMD_2BCLK);
    run(0, 1, 1, 2'h1, 24'h5a_5a5a, 6'h2f, 8 * `ISA_T_CMD_3BCLK);
    run(0, 0, 1, 2'h2, 24'hc3_0f00, 6'h1f, 8 * `ISA_T_CMD_4BCLK);
    run(0, 1, 0, 2'h0, 24'h0f_1234, 6'h3b, 8 * `ISA_T_CMD_2BCLK);
    run(0, 0, 0, 2'h1, 24'h01_0001, 6'h37, 8 * `ISA_T_CMD_3BCLK);
    run(0, 1, 0, 2'h3, 24'h7e_0003, 6'h2f, 8 * `ISA_T_CMD_7BCLK);
  endtask
  task automatic t_io;
    run(1, 0, 1, 2'h1, 24'h00_03f8, 6'h3d, 8 * `ISA_T_CMD_3BCLK);
    run(1, 1, 0, 2'h1, 24'h00_0061, 6'h3e, 8 * `ISA_T_CMD_3BCLK);
  endtask
  // Widths that have no such cycle length must leave the bus untouched
  task automatic t_refuse;
    run(0, 0, 1, 2'h3, 24'h12_3456, 6'h3f, 0);
    run(0, 1, 0, 2'h2, 24'h34_5678, 6'h3f, 0);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    t_memory();
    t_io();
    t_refuse();
    conclude();
  end
endmodule // isa_master_cycle_sequencer_tb_top
